// ===== ext_irq_regs.svh
// register map and field constants of the external request pin block
// assumes a 32-bit bus with byte offsets in the low address bits
`ifndef EXT_IRQ_REGS_SVH
`define EXT_IRQ_REGS_SVH

`define EIR_ADDR_W      4
`define EIR_CTRL_OFS    4'h0
`define EIR_STAT_OFS    4'h4
`define EIR_MASK_OFS    4'h8

`define EIR_CTRL_RST    8'h00
`define EIR_CTRL_WMASK  8'h73
`define EIR_EVT_RST     2'h0
`define EIR_NUM_EVT     2
`define EIR_EVT_PIN     0
`define EIR_EVT_HOLD    1

`define EIR_BIT_PDD     6
`define EIR_BIT_EDG     5
`define EIR_BIT_PE      4
`define EIR_BIT_FLAG    3
`define EIR_BIT_ACK     2
`define EIR_BIT_IE      1
`define EIR_BIT_MOD     0

`define EIR_ZERO32      32'h0000_0000
`define EIR_ZERO24      24'h00_0000
`define EIR_ZERO30      30'h0000_0000

`endif

// ===== ext_irq_pkg.sv
// types shared by the external request pin block
// constants live in ext_irq_regs.svh
package ext_irq_pkg;

  typedef struct packed {
    logic reserved;
    logic pullDeviceDisable;
    logic polaritySelect;
    logic requestPinEnable;
    logic requestEventFlag;
    logic requestAcknowledge;
    logic requestInterruptEnable;
    logic detectionMode;
  } ctrl_t;

  typedef struct packed {
    logic enable;
    logic polarity;
    logic mode;
  } detect_cfg_t;

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'h1,
    BUS_ANSWER = 2'h2
  } bus_state_t;

  typedef enum logic [3:0] {
    SEL_NONE = 4'h1,
    SEL_CTRL = 4'h2,
    SEL_STAT = 4'h4,
    SEL_MASK = 4'h8
  } reg_sel_t;

endpackage : ext_irq_pkg

// ===== pin_event_detect.sv
// pin synchroniser and edge/level event detector
// assumes pinIn may be asynchronous; rstN is already synchronised
`timescale 1ns/1ns
`default_nettype none
module pin_event_detect (
  input  wire logic                      ref_clk,
  input  wire logic                      rstN,
  input  wire logic                      ce,
  input  wire logic                      pinIn,
  input  wire ext_irq_pkg::detect_cfg_t  cfg,
  output logic                           eventPulse,
  output logic                           levelAsserted
);
  logic syncA;
  logic syncB;
  logic prev;
  logic next_syncA;
  logic next_syncB;
  logic next_prev;
  logic asserted;
  logic edgeSeen;

  always_comb begin
    next_syncA = pinIn;
    next_syncB = syncA;
    next_prev  = syncB;
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      syncA <= 1'b1;
      syncB <= 1'b1;
      prev  <= 1'b1;
    end else if (ce) begin
      syncA <= next_syncA;
      syncB <= next_syncB;
      prev  <= next_prev;
    end
  end

  always_comb begin
    asserted      = cfg.polarity ? syncB : !syncB;
    edgeSeen      = cfg.polarity ? (syncB & !prev) : (!syncB & prev);
    levelAsserted = cfg.enable & asserted;
    eventPulse    = cfg.enable & ce & (edgeSeen | (cfg.mode & asserted));
  end

  property p_fall_edge;
    @(posedge ref_clk) disable iff (!rstN)
      (ce && cfg.enable && !cfg.polarity && prev && !syncB) |-> eventPulse;
  endproperty
  a_fall_edge: assert property (p_fall_edge) else $error("falling edge missed");

  property p_pin_off;
    @(posedge ref_clk) disable iff (!rstN)
      !cfg.enable |-> !eventPulse && !levelAsserted;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("event while pin disabled");

  property p_edge_only;
    @(posedge ref_clk) disable iff (!rstN)
      (ce && cfg.enable && !cfg.mode && prev == syncB) |-> !eventPulse;
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("event without edge");

endmodule : pin_event_detect
`default_nettype wire

// ===== ext_request_irq.sv
// external request pin controller with Avalon-MM register slave
// assumes pin driven by an outside source; one clock, async low reset
//
// Implementation choices: the Avalon-MM register port and the address map.
`include "ext_irq_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module ext_request_irq (
  input  wire logic                    ref_clk,
  input  wire logic                    reset_n,
  input  wire logic                    ce,
  input  wire logic                    irqPin,
  input  wire logic [`EIR_ADDR_W-1:0]  address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [31:0]             writedata,
  input  wire logic [3:0]              byteenable,
  output logic      [31:0]             readdata,
  output logic                         waitrequest,
  output logic                         irqToCpu,
  output logic                         pullUpEnable,
  output logic                         pullDownEnable
);
  logic                       rstMeta;
  logic                       rstN;
  ext_irq_pkg::ctrl_t         ctrl;
  ext_irq_pkg::ctrl_t         next_ctrl;
  ext_irq_pkg::bus_state_t    busState;
  ext_irq_pkg::bus_state_t    next_busState;
  ext_irq_pkg::detect_cfg_t   cfg;
  ext_irq_pkg::reg_sel_t      sel;
  logic [`EIR_NUM_EVT-1:0]    evtStatus;
  logic [`EIR_NUM_EVT-1:0]    next_evtStatus;
  logic [`EIR_NUM_EVT-1:0]    evtMask;
  logic [`EIR_NUM_EVT-1:0]    next_evtMask;
  logic [`EIR_NUM_EVT-1:0]    evtRaw;
  logic [31:0]                next_readdata;
  logic                       next_waitrequest;
  logic                       next_irqToCpu;
  logic                       next_pullUpEnable;
  logic                       next_pullDownEnable;
  logic                       eventPulse;
  logic                       levelAsserted;
  logic                       wrTaken;
  logic                       wrCtrl;
  logic                       wrStat;
  logic                       wrMask;
  logic                       ackClear;
  logic                       holdBlock;
  logic                       pullOn;

  function automatic ext_irq_pkg::reg_sel_t regDecode(input logic [`EIR_ADDR_W-1:0] a);
    case (a)
      `EIR_CTRL_OFS: regDecode = ext_irq_pkg::SEL_CTRL;
      `EIR_STAT_OFS: regDecode = ext_irq_pkg::SEL_STAT;
      `EIR_MASK_OFS: regDecode = ext_irq_pkg::SEL_MASK;
      default:       regDecode = ext_irq_pkg::SEL_NONE;
    endcase
  endfunction : regDecode

  // reset release is synchronised; assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  always_comb begin
    cfg.enable   = ctrl.requestPinEnable;
    cfg.polarity = ctrl.polaritySelect;
    cfg.mode     = ctrl.detectionMode;
  end

  pin_event_detect u_detect (
    .ref_clk       (ref_clk),
    .rstN          (rstN),
    .ce            (ce),
    .pinIn         (irqPin),
    .cfg           (cfg),
    .eventPulse    (eventPulse),
    .levelAsserted (levelAsserted)
  );

  // bus: one wait cycle, then waitrequest low for exactly one edge
  always_comb begin
    sel              = regDecode(address);
    next_busState    = busState;
    next_waitrequest = 1'b1;
    next_readdata    = `EIR_ZERO32;
    case (busState)
      ext_irq_pkg::BUS_IDLE: begin
        if (read || write) begin
          next_busState    = ext_irq_pkg::BUS_ANSWER;
          next_waitrequest = 1'b0;
          if (read) begin
            case (sel)
              ext_irq_pkg::SEL_CTRL: next_readdata = {`EIR_ZERO24, ctrl};
              ext_irq_pkg::SEL_STAT: next_readdata = {`EIR_ZERO30, evtStatus};
              ext_irq_pkg::SEL_MASK: next_readdata = {`EIR_ZERO30, evtMask};
              default:               next_readdata = `EIR_ZERO32;
            endcase
          end
        end
      end
      ext_irq_pkg::BUS_ANSWER: begin
        next_busState = ext_irq_pkg::BUS_IDLE;
      end
      default: begin
        next_busState = ext_irq_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      busState    <= ext_irq_pkg::BUS_IDLE;
      waitrequest <= 1'b1;
      readdata    <= `EIR_ZERO32;
    end else if (ce) begin
      busState    <= next_busState;
      waitrequest <= next_waitrequest;
      readdata    <= next_readdata;
    end
  end

  // writes land on the same edge the master sees waitrequest low
  always_comb begin
    wrTaken   = write && !waitrequest && byteenable[0];
    wrCtrl    = wrTaken && (sel == ext_irq_pkg::SEL_CTRL);
    wrStat    = wrTaken && (sel == ext_irq_pkg::SEL_STAT);
    wrMask    = wrTaken && (sel == ext_irq_pkg::SEL_MASK);
    ackClear  = wrCtrl && writedata[`EIR_BIT_ACK];
    holdBlock = ctrl.detectionMode && levelAsserted;
  end

  always_comb begin
    next_ctrl = ctrl;
    if (wrCtrl) begin
      next_ctrl = ext_irq_pkg::ctrl_t'((ctrl & ~`EIR_CTRL_WMASK) | (writedata[7:0] & `EIR_CTRL_WMASK));
    end
    next_ctrl.reserved           = 1'b0;
    next_ctrl.requestAcknowledge = 1'b0;
    // set beats acknowledge so a same-cycle event is never lost
    if (eventPulse) begin
      next_ctrl.requestEventFlag = 1'b1;
    end else if (ackClear && !holdBlock) begin
      next_ctrl.requestEventFlag = 1'b0;
    end else begin
      next_ctrl.requestEventFlag = ctrl.requestEventFlag;
    end
  end

  always_comb begin
    evtRaw[`EIR_EVT_PIN]  = eventPulse;
    evtRaw[`EIR_EVT_HOLD] = ackClear && holdBlock;
    next_evtMask          = wrMask ? writedata[`EIR_NUM_EVT-1:0] : evtMask;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `EIR_NUM_EVT; gi = gi + 1) begin : g_sticky
      assign next_evtStatus[gi] = evtRaw[gi] | (evtStatus[gi] & !(wrStat && writedata[gi]));
    end
  endgenerate

  always_comb begin
    pullOn              = ctrl.requestPinEnable && !ctrl.pullDeviceDisable;
    next_pullUpEnable   = pullOn && !ctrl.polaritySelect;
    next_pullDownEnable = pullOn && ctrl.polaritySelect;
    next_irqToCpu       = (ctrl.requestEventFlag && ctrl.requestInterruptEnable)
                          || |(evtStatus & evtMask);
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      ctrl           <= ext_irq_pkg::ctrl_t'(`EIR_CTRL_RST);
      evtStatus      <= `EIR_EVT_RST;
      evtMask        <= `EIR_EVT_RST;
      pullUpEnable   <= 1'b0;
      pullDownEnable <= 1'b0;
      irqToCpu       <= 1'b0;
    end else if (ce) begin
      ctrl           <= next_ctrl;
      evtStatus      <= next_evtStatus;
      evtMask        <= next_evtMask;
      pullUpEnable   <= next_pullUpEnable;
      pullDownEnable <= next_pullDownEnable;
      irqToCpu       <= next_irqToCpu;
    end
  end

  property p_pull_on;
    @(posedge ref_clk) disable iff (!rstN)
      ce |=> (pullUpEnable || pullDownEnable)
             == $past(ctrl.requestPinEnable && !ctrl.pullDeviceDisable);
  endproperty
  a_pull_on: assert property (p_pull_on) else $error("pull device state wrong");

  property p_pull_down;
    @(posedge ref_clk) disable iff (!rstN)
      (ce && ctrl.requestPinEnable && !ctrl.pullDeviceDisable && ctrl.polaritySelect)
        |=> pullDownEnable && !pullUpEnable;
  endproperty
  a_pull_down: assert property (p_pull_down) else $error("pull not turned down");

  property p_flag_set;
    @(posedge ref_clk) disable iff (!rstN)
      (ce && eventPulse) |=> ctrl.requestEventFlag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event did not set flag");

  property p_ack_reads_zero;
    @(posedge ref_clk) disable iff (!rstN)
      !waitrequest |-> !readdata[`EIR_BIT_ACK] && !ctrl.requestAcknowledge;
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("acknowledge read as one");

  property p_ack_clears;
    @(posedge ref_clk) disable iff (!rstN)
      (ce && ackClear && !holdBlock && !eventPulse) |=> !ctrl.requestEventFlag;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("acknowledge did not clear");

  property p_level_hold;
    @(posedge ref_clk) disable iff (!rstN)
      (ce && ctrl.requestEventFlag && holdBlock) |=> ctrl.requestEventFlag;
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("flag cleared during level");

  property p_irq_follow;
    @(posedge ref_clk) disable iff (!rstN)
      ce |=> irqToCpu == $past((ctrl.requestEventFlag && ctrl.requestInterruptEnable)
                               || |(evtStatus & evtMask));
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("processor request mismatch");

  property p_flag_sticky;
    @(posedge ref_clk) disable iff (!rstN)
      (ctrl.requestEventFlag && !ackClear) |=> ctrl.requestEventFlag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without ack");

  property p_bus_answer;
    @(posedge ref_clk) disable iff (!rstN)
      (ce && (read || write) && waitrequest && busState == ext_irq_pkg::BUS_IDLE)
        |=> !waitrequest ##1 (waitrequest || !ce);
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing off");

  // writing zero to the acknowledge bit must leave the flag alone
  property p_ack_zero_keeps;
    @(posedge ref_clk) disable iff (!rstN)
      (ce && wrCtrl && !writedata[`EIR_BIT_ACK] && !eventPulse)
        |=> ctrl.requestEventFlag == $past(ctrl.requestEventFlag);
  endproperty
  a_ack_zero_keeps: assert property (p_ack_zero_keeps) else $error("zero write changed flag");

  property p_irq_quiet;
    @(posedge ref_clk) disable iff (!rstN)
      (ce && !ctrl.requestInterruptEnable && (evtStatus & evtMask) == `EIR_EVT_RST) |=> !irqToCpu;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("request raised while disabled");

  // a refused acknowledge leaves a trace software can see
  property p_hold_status;
    @(posedge ref_clk) disable iff (!rstN)
      (ce && ackClear && holdBlock) |=> evtStatus[`EIR_EVT_HOLD];
  endproperty
  a_hold_status: assert property (p_hold_status) else $error("refused ack not recorded");

  property p_pull_up;
    @(posedge ref_clk) disable iff (!rstN)
      (ce && ctrl.requestPinEnable && !ctrl.pullDeviceDisable && !ctrl.polaritySelect)
        |=> pullUpEnable && !pullDownEnable;
  endproperty
  a_pull_up: assert property (p_pull_up) else $error("pull-up not connected");

  property p_pull_idle;
    @(posedge ref_clk) disable iff (!rstN)
      (ce && !ctrl.requestPinEnable) |=> !pullUpEnable && !pullDownEnable;
  endproperty
  a_pull_idle: assert property (p_pull_idle) else $error("pull on while pin disabled");

  // level mode: an asserted level counts as an event every cycle
  property p_level_event;
    @(posedge ref_clk) disable iff (!rstN)
      (ce && ctrl.detectionMode && levelAsserted) |-> eventPulse;
  endproperty
  a_level_event: assert property (p_level_event) else $error("asserted level not seen");

  // read data is zero outside the answer cycle, so stale values never leak
  property p_idle_readdata;
    @(posedge ref_clk) disable iff (!rstN)
      waitrequest |-> readdata == `EIR_ZERO32;
  endproperty
  a_idle_readdata: assert property (p_idle_readdata) else $error("read data outside answer");

endmodule : ext_request_irq
`default_nettype wire

// ===== ext_pin_source.sv
// model of the outside source that drives the request pin
// assumes drive and level change just after a rising edge of ref_clk
`timescale 1ns/1ns
`default_nettype none
module ext_pin_source (
  input  wire logic ref_clk,
  input  wire logic drive,
  input  wire logic level,
  input  wire logic pullUpEnable,
  input  wire logic pullDownEnable,
  output logic      pin
);
  logic last = 1'b1;
  always @(posedge ref_clk) begin
    last <= pin;
  end
  // released pin with no pull toggles so no stale level is trusted
  always_comb begin
    if (drive) pin = level;
    else if (pullUpEnable) pin = 1'b1;
    else if (pullDownEnable) pin = 1'b0;
    else pin = ~last;
  end
endmodule : ext_pin_source
`default_nettype wire

// ===== ext_request_irq_bench.sv
// self-checking bench of the external request pin controller
// assumes ext_irq_pkg and ext_irq_regs.svh are visible
`include "ext_irq_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module ext_request_irq_bench;
  localparam logic [7:0] PE = 8'h10, IE = 8'h02, EDG = 8'h20, MD = 8'h01, ACK = 8'h04, FLG = 8'h08;
  localparam logic [7:0] NOPULL = 8'h40;
  logic        ref_clk = 1'b0, reset_n = 1'b0, ce = 1'b1, read = 1'b0, write = 1'b0;
  logic [3:0]  address = 4'h0, byteenable = 4'hf;
  logic [31:0] writedata = 32'h0000_0000, readdata, rd;
  logic        waitrequest, irqToCpu, pullUpEnable, pullDownEnable, irqPin;
  logic        drive = 1'b1, level = 1'b1, pol, ie;
  int          mismatches = 0, n_compared = 0;

  always #2 ref_clk = ~ref_clk;

  ext_request_irq u_ext_request_irq (.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .irqPin(irqPin),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .irqToCpu(irqToCpu), .pullUpEnable(pullUpEnable),
    .pullDownEnable(pullDownEnable));
  ext_pin_source u_ext_pin_source (.ref_clk(ref_clk), .drive(drive), .level(level),
    .pullUpEnable(pullUpEnable), .pullDownEnable(pullDownEnable), .pin(irqPin));

  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic check_out(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: output %b expected %b", $time, got, exp);
    end
  endtask : check_out

  // one Avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic be);
    int n;
    n = 0;
    @(posedge ref_clk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= {24'h00_0000, d};
    byteenable <= {3'h7, be};
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      mismatches++;
      $display("Error at %0t: bus answer timed out", $time);
      report_and_stop();
    end
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b1);
  endtask : wr

  task automatic check_reg(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 1'b1);
    n_compared++;
    if (rd !== {24'h00_0000, exp}) begin
      mismatches++;
      $display("Error at %0t: reg %h read %h expected %h", $time, a, rd, exp);
    end
  endtask : check_reg

  task automatic wait_n(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : wait_n

  task automatic pin_pulse(input logic act, input int w);
    @(posedge ref_clk);
    level <= act;
    repeat (w) @(posedge ref_clk);
    level <= ~act;
    wait_n(5);
  endtask : pin_pulse

  function automatic logic [1:0] pull_exp(input logic pe, input logic pdd, input logic edg);
    return {pe & ~pdd & ~edg, pe & ~pdd & edg};
  endfunction : pull_exp

  initial begin
    void'($urandom(32'he8ab_514e));
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    wr(4'hc, 8'hff);
    check_reg(`EIR_CTRL_OFS, 8'h00);
    check_reg(`EIR_STAT_OFS, 8'h00);
    check_reg(`EIR_MASK_OFS, 8'h00);
    check_reg(4'hc, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr(`EIR_CTRL_OFS, {1'b0, i[1], i[0], i[2], 4'h0});
      wait_n(2);
      check_out({pullUpEnable, pullDownEnable}, pull_exp(i[2], i[1], i[0]));
    end
    $display("test pull done");
    wr(`EIR_CTRL_OFS, PE | IE | ACK);
    wr(`EIR_STAT_OFS, 8'h03);
    pin_pulse(1'b0, 2);
    check_reg(`EIR_CTRL_OFS, PE | IE | FLG);
    check_out({1'b0, irqToCpu}, 2'h1);
    check_reg(`EIR_STAT_OFS, 8'h01);
    bus(1'b1, `EIR_CTRL_OFS, PE | IE | ACK, 1'b0);
    wr(`EIR_CTRL_OFS, PE | IE);
    check_reg(`EIR_CTRL_OFS, PE | IE | FLG);
    wr(`EIR_CTRL_OFS, PE | IE | ACK);
    check_reg(`EIR_CTRL_OFS, PE | IE);
    check_out({1'b0, irqToCpu}, 2'h0);
    $display("test edge ack done");
    for (int i = 0; i < 6; i++) begin
      pol = 1'($urandom % 2);
      ie = 1'($urandom % 2);
      wr(`EIR_CTRL_OFS, 8'h00);
      @(posedge ref_clk);
      level <= ~pol;
      wait_n(4);
      wr(`EIR_CTRL_OFS, PE | ACK | (pol ? EDG : 8'h00) | (ie ? IE : 8'h00));
      wr(`EIR_STAT_OFS, 8'h03);
      check_reg(`EIR_CTRL_OFS, PE | (pol ? EDG : 8'h00) | (ie ? IE : 8'h00));
      pin_pulse(pol, 1 + int'($urandom % 4));
      check_reg(`EIR_CTRL_OFS, PE | FLG | (pol ? EDG : 8'h00) | (ie ? IE : 8'h00));
      check_out({1'b0, irqToCpu}, {1'b0, ie});
    end
    $display("test random polarity done");
    wr(`EIR_CTRL_OFS, 8'h00);
    @(posedge ref_clk);
    level <= 1'b1;
    wait_n(4);
    wr(`EIR_MASK_OFS, 8'h01);
    wr(`EIR_CTRL_OFS, PE | ACK);
    wr(`EIR_STAT_OFS, 8'h03);
    pin_pulse(1'b0, 2);
    check_out({1'b0, irqToCpu}, 2'h1);
    wr(`EIR_STAT_OFS, 8'h01);
    wait_n(2);
    check_out({1'b0, irqToCpu}, 2'h0);
    wr(`EIR_MASK_OFS, 8'h00);
    wr(`EIR_CTRL_OFS, IE | ACK);
    pin_pulse(1'b0, 3);
    check_reg(`EIR_CTRL_OFS, IE);
    check_out({1'b0, irqToCpu}, 2'h0);
    $display("test mask and disable done");
    // released pin: pull-up holds it idle, without pull it wanders and makes edges
    wr(`EIR_CTRL_OFS, PE | ACK);
    wait_n(2);
    @(posedge ref_clk);
    drive <= 1'b0;
    wait_n(5);
    check_reg(`EIR_CTRL_OFS, PE);
    wr(`EIR_CTRL_OFS, NOPULL | PE);
    wait_n(5);
    check_reg(`EIR_CTRL_OFS, NOPULL | PE | FLG);
    @(posedge ref_clk);
    drive <= 1'b1;
    wait_n(4);
    $display("test pull release done");
    wr(`EIR_CTRL_OFS, PE | MD | ACK);
    wr(`EIR_STAT_OFS, 8'h03);
    @(posedge ref_clk);
    level <= 1'b0;
    wait_n(5);
    wr(`EIR_CTRL_OFS, PE | MD | ACK);
    check_reg(`EIR_CTRL_OFS, PE | MD | FLG);
    check_reg(`EIR_STAT_OFS, 8'h03);
    @(posedge ref_clk);
    level <= 1'b1;
    wait_n(5);
    wr(`EIR_CTRL_OFS, PE | MD | ACK);
    check_reg(`EIR_CTRL_OFS, PE | MD);
    $display("test level mode done");
    @(posedge ref_clk);
    ce <= 1'b0;
    pin_pulse(1'b0, 3);
    @(posedge ref_clk);
    ce <= 1'b1;
    wait_n(4);
    check_reg(`EIR_CTRL_OFS, PE | MD);
    check_out({1'b0, irqToCpu}, 2'h0);
    $display("test clock enable freeze done");
    wr(`EIR_CTRL_OFS, PE | IE);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    wait_n(3);
    check_out({pullUpEnable, pullDownEnable}, 2'h0);
    check_reg(`EIR_CTRL_OFS, 8'h00);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule : ext_request_irq_bench
`default_nettype wire
